// ===== bench/tb.sv
// Self-checking bench for the radio mode sequencer
`timescale 1ns/1ps
module tb;
  import rms_pkg::*;
  logic clk_i = 1'b0; // 50 MHz system clock
  logic rst_i = 1'b1; // Synchronous reset
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus request
  logic [3:0] adr = 4'h0; // Byte address
  logic [3:0] sel = 4'h0; // Byte lanes
  logic relaunch; // Receive restart pulse
  logic [31:0] wdat = 32'h0; // Write data
  logic [31:0] rdat; // Read data
  logic ack; // Bus answer
  logic [10:0] ev = 11'h000; // Event pulses, one bit each
  logic sleep_lvl = 1'b0; // Chip low-power mode before launch
  logic [2:0] mode; // Chip mode out
  int failures = 0;
  int checks = 0;
  // Small resolutions keep the timer waits short
  rms_sequencer #(.RES1_CYC(4), .RES2_CYC(8), .RES3_CYC(16)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tx_done_event_i(ev[0]), .rx_payload_event_i(ev[1]), .check_pass_event_i(ev[2]),
    .strength_event_i(ev[3]), .match_event_i(ev[4]), .lead_in_event_i(ev[5]),
    .queue_level_event_i(ev[6]), .queue_drained_event_i(ev[7]),
    .strength_timeout_i(ev[8]), .lead_in_timeout_i(ev[9]), .match_timeout_i(ev[10]),
    .chip_sleep_i(sleep_lvl), .chip_mode_o(mode), .seq_active_o(),
    .reception_relaunch_o(relaunch)
  );
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // Result and verdict
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_mode(input logic [2:0] got, input logic [2:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: chip mode %h expected %h", $time, got, exp);
    end
  endtask : cmp_mode
  // Classic single cycle; holds the request until ack is sampled high
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100) cmp_word(32'h1, 32'h0);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0; sel <= 4'h0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  // Config word from its fields
  function automatic logic [31:0] cfg(input logic idl, input logic [1:0] st, input logic lp,
      input logic iex, input logic tex, input logic [2:0] rx, input logic [1:0] to,
      input logic [2:0] pkt, input logic crc);
    return {17'h0, crc, pkt, to, rx, tex, iex, lp, st, idl};
  endfunction : cfg
  // One-cycle event pulse
  task automatic pulse(input logic [10:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 11'h000;
  endtask : pulse
  // Status state, mode and active bit; initial-sleep bit masked
  task automatic expect_st(input logic [2:0] st, input logic [2:0] md);
    logic [31:0] q;
    bus(1'b0, 4'hc, 32'h0, q);
    cmp_word(q & 32'h0000_0277, {22'h0, st != 3'h0, 2'h0, md, 1'b0, st});
    cmp_mode(mode, md);
  endtask : expect_st
  task automatic t_reset;
    logic [31:0] q;
    bus(1'b0, 4'h0, 32'h0, q);
    cmp_word(q, 32'h0);
    bus(1'b0, 4'h8, 32'h0, q);
    cmp_word(q, 32'h0);
    bus(1'b0, 4'h4, 32'h0, q);
    cmp_word(q, 32'h0);
    expect_st(3'h0, 3'h1);
  endtask : t_reset
  // Launch from sleep into idle standby, stop restores sleep
  task automatic t_idle_stop;
    sleep_lvl <= 1'b1;
    wr(4'h0, cfg(1'b0, 2'b00, 1'b1, 1'b0, 1'b0, 3'h0, 2'h0, 3'h0, 1'b0));
    wr(4'h4, 32'h1);
    expect_st(3'h1, 3'h1);
    pulse(11'h7ff);
    expect_st(3'h1, 3'h1);
    sleep_lvl <= 1'b0;
    wr(4'h4, 32'h2);
    expect_st(3'h0, 3'h0);
  endtask : t_idle_stop
  // Receive, packet done back to receive, then timeout halts
  task automatic t_rx_path;
    wr(4'h0, cfg(1'b1, 2'b01, 1'b0, 1'b0, 1'b0, 3'h1, 2'h3, 3'h4, 1'b0));
    wr(4'h4, 32'h1);
    expect_st(3'h4, 3'h4);
    pulse(11'h002);
    expect_st(3'h4, 3'h4);
    pulse(11'h200);
    expect_st(3'h0, 3'h1);
  endtask : t_rx_path
  // Transmit to receive, match halts
  task automatic t_tx_path;
    wr(4'h0, cfg(1'b0, 2'b10, 1'b0, 1'b0, 1'b1, 3'h5, 2'h0, 3'h0, 1'b0));
    wr(4'h4, 32'h1);
    expect_st(3'h3, 3'h3);
    pulse(11'h001);
    expect_st(3'h4, 3'h4);
    pulse(11'h004);
    expect_st(3'h4, 3'h4);
    pulse(11'h100);
    @(posedge clk_i);
    cmp_word({31'h0, relaunch}, 32'h1);
    expect_st(3'h4, 3'h4);
    pulse(11'h010);
    expect_st(3'h0, 3'h1);
  endtask : t_tx_path
  // Transmit waits for the queue level event
  task automatic t_level;
    wr(4'h0, cfg(1'b0, 2'b11, 1'b0, 1'b0, 1'b0, 3'h0, 2'h0, 3'h0, 1'b0));
    wr(4'h4, 32'h1);
    pulse(11'h040);
    expect_st(3'h3, 3'h3);
    wr(4'h4, 32'h2);
    expect_st(3'h0, 3'h1);
  endtask : t_level
  // Failed check with crc on takes the timeout path; a good check does not
  task automatic t_crc;
    wr(4'h0, cfg(1'b0, 2'b01, 1'b1, 1'b0, 1'b0, 3'h3, 2'h2, 3'h4, 1'b1));
    wr(4'h4, 32'h1);
    pulse(11'h006);
    expect_st(3'h4, 3'h4);
    pulse(11'h002);
    expect_st(3'h1, 3'h1);
    wr(4'h4, 32'h2);
    wr(4'h0, cfg(1'b0, 2'b01, 1'b0, 1'b0, 1'b0, 3'h2, 2'h0, 3'h0, 1'b0));
    wr(4'h4, 32'h1);
    pulse(11'h002);
    expect_st(3'h0, 3'h1);
  endtask : t_crc
  // First timer 16 cycles, second 32 cycles; idle exits to receive, second timer back
  task automatic t_timer;
    wr(4'h8, 32'h0008_0405);
    wr(4'h0, cfg(1'b0, 2'b00, 1'b1, 1'b1, 1'b0, 3'h0, 2'h0, 3'h0, 1'b0));
    wr(4'h4, 32'h1);
    expect_st(3'h1, 3'h1);
    repeat (20) @(posedge clk_i);
    expect_st(3'h4, 3'h4);
    repeat (28) @(posedge clk_i);
    expect_st(3'h1, 3'h1);
    wr(4'h4, 32'h2);
    expect_st(3'h0, 3'h1);
  endtask : t_timer
  // Hang guard, far beyond the expected run length
  initial begin
    #400000;
    failures++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_idle_stop();
    t_rx_path();
    t_tx_path();
    t_level();
    t_crc();
    t_timer();
    close_out();
  end
endmodule : tb

// ===== logic/rms_map.svh
// Register map, field positions, reset values and timing constants of the mode sequencer
`ifndef RMS_MAP_SVH
`define RMS_MAP_SVH
// Word offsets on the bus (byte address bits 3:2)
`define RMS_OFS_CONFIG 2'h0
`define RMS_OFS_CONTROL 2'h1
`define RMS_OFS_TIMER 2'h2
`define RMS_OFS_STATUS 2'h3
// Configuration word fields
`define RMS_F_IDLE_SEL 0
`define RMS_F_START_LO 1
`define RMS_F_START_HI 2
`define RMS_F_LP_CHOICE 3
`define RMS_F_IDLE_EXIT 4
`define RMS_F_TX_EXIT 5
`define RMS_F_RX_LO 6
`define RMS_F_RX_HI 8
`define RMS_F_TO_LO 9
`define RMS_F_TO_HI 10
`define RMS_F_PKT_LO 11
`define RMS_F_PKT_HI 13
`define RMS_F_CRC_ON 14
`define RMS_CONFIG_W 15
`define RMS_CONFIG_RST 15'h0000
// Control word fields (write-only pulses)
`define RMS_F_LAUNCH 0
`define RMS_F_STOP 1
// Timer word fields
`define RMS_F_T1_SCALE_LO 0
`define RMS_F_T1_SCALE_HI 1
`define RMS_F_T2_SCALE_LO 2
`define RMS_F_T2_SCALE_HI 3
`define RMS_F_T1_CNT_LO 8
`define RMS_F_T1_CNT_HI 15
`define RMS_F_T2_CNT_LO 16
`define RMS_F_T2_CNT_HI 23
`define RMS_TIMER_RST 24'h000000
// Timer resolutions in nanoseconds and the clock period
`define RMS_CLK_NS 20
`define RMS_RES1_NS 64000
`define RMS_RES2_NS 4100000
`define RMS_RES3_NS 262000000
`endif

// ===== logic/rms_pkg.sv
// Types shared by the mode sequencer files
package rms_pkg;
  // Sequencer resting and active states
  typedef enum logic [2:0] {
    st_halted, st_idle, st_tx_wait_level, st_tx, st_rx, st_pkt_done, st_pkt_wait_drain, st_synth
  } rms_state_type;
  // Chip mode driven to the mode controller
  typedef enum logic [2:0] {
    mode_sleep, mode_standby, mode_synth, mode_tx, mode_rx
  } rms_mode_type;
endpackage : rms_pkg

// ===== logic/rms_sequencer.sv
// Top-level radio mode sequencer with its classic Wishbone register slave
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "rms_map.svh"
module rms_sequencer import rms_pkg::*; #(
  parameter int unsigned RES1_CYC = `RMS_RES1_NS / `RMS_CLK_NS,
  parameter int unsigned RES2_CYC = `RMS_RES2_NS / `RMS_CLK_NS,
  parameter int unsigned RES3_CYC = `RMS_RES3_NS / `RMS_CLK_NS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Events from packet engine and receiver (one-cycle pulses, same clock)
  input wire logic tx_done_event_i,
  input wire logic rx_payload_event_i,
  input wire logic check_pass_event_i,
  input wire logic strength_event_i,
  input wire logic match_event_i,
  input wire logic lead_in_event_i,
  input wire logic queue_level_event_i,
  input wire logic queue_drained_event_i,
  input wire logic strength_timeout_i,
  input wire logic lead_in_timeout_i,
  input wire logic match_timeout_i,
  // Chip low-power mode before launch: 1 sleep, 0 standby
  input wire logic chip_sleep_i,
  // Mode controller side
  output logic [2:0] chip_mode_o,
  output logic seq_active_o,
  output logic reception_relaunch_o
);
  // Configuration and timer registers
  logic [`RMS_CONFIG_W-1:0] config_reg;
  logic [23:0] timer_reg;
  logic seq_launch; // Launch pulse from a control write
  logic seq_stop; // Stop pulse from a control write
  logic ack_reg; // Bus acknowledge
  logic [31:0] rdata_reg; // Read data held while ack is high
  logic wr_take; // Write takes effect at this edge
  // Sequencer state
  rms_state_type state_reg, state_next;
  logic init_sleep_reg; // Low-power mode caught at launch
  logic ran_reg; // Sequencer has run since reset
  logic halt_sleep; // Low-power mode shown while halted
  logic relaunch_next;
  // Timer chain
  logic [1:0] tick;
  logic [1:0] tick_start;
  logic first_timer_event, second_timer_event;
  // Decoded configuration fields
  logic idle_lowpower_select, lowpower_choice, idle_exit_select, tx_exit_select, crc_on;
  logic [1:0] start_exit_select, timeout_exit_select;
  logic [2:0] rx_exit_select, pkt_done_exit_select;
  logic receive_timeout;
  rms_state_type lowpower_target, timeout_target;

  assign idle_lowpower_select = config_reg[`RMS_F_IDLE_SEL];
  assign start_exit_select = config_reg[`RMS_F_START_HI:`RMS_F_START_LO];
  assign lowpower_choice = config_reg[`RMS_F_LP_CHOICE];
  assign idle_exit_select = config_reg[`RMS_F_IDLE_EXIT];
  assign tx_exit_select = config_reg[`RMS_F_TX_EXIT];
  assign rx_exit_select = config_reg[`RMS_F_RX_HI:`RMS_F_RX_LO];
  assign timeout_exit_select = config_reg[`RMS_F_TO_HI:`RMS_F_TO_LO];
  assign pkt_done_exit_select = config_reg[`RMS_F_PKT_HI:`RMS_F_PKT_LO];
  assign crc_on = config_reg[`RMS_F_CRC_ON];

  // Bus: one wait state, ack for one cycle, unmapped words read zero
  assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // Acknowledge: rises one cycle after the request, drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
    end
  end

  // Read data captured when the request arrives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !ack_reg && !wb_we_i) begin
      if (wb_adr_i[3:2] == `RMS_OFS_CONFIG) begin
        rdata_reg <= {17'h00000, config_reg};
      end else if (wb_adr_i[3:2] == `RMS_OFS_TIMER) begin
        rdata_reg <= {8'h00, timer_reg};
      end else if (wb_adr_i[3:2] == `RMS_OFS_STATUS) begin
        // State, driven mode, caught initial mode, active flag
        rdata_reg <= {22'h000000, seq_active_o, init_sleep_reg, 1'b0, chip_mode_o, 1'b0, state_reg};
      end else begin
        rdata_reg <= 32'h00000000; // Control word and unmapped read zero
      end
    end
  end

  // Configuration register, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_reg <= `RMS_CONFIG_RST;
    end else if (wr_take && (wb_adr_i[3:2] == `RMS_OFS_CONFIG)) begin
      if (wb_sel_i[0]) begin
        config_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        config_reg[`RMS_CONFIG_W-1:8] <= wb_dat_i[`RMS_CONFIG_W-1:8];
      end
    end
  end

  // Timer settings register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_reg <= `RMS_TIMER_RST;
    end else if (wr_take && (wb_adr_i[3:2] == `RMS_OFS_TIMER)) begin
      if (wb_sel_i[0]) begin
        timer_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        timer_reg[15:8] <= wb_dat_i[15:8];
      end
      if (wb_sel_i[2]) begin
        timer_reg[23:16] <= wb_dat_i[23:16];
      end
    end
  end

  // Control pulses; launch only counts from the halted state.
  // Software keeps launch and stop apart; if both arrive stop wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_launch <= 1'b0;
      seq_stop <= 1'b0;
    end else begin
      seq_stop <= wr_take && (wb_adr_i[3:2] == `RMS_OFS_CONTROL) && wb_sel_i[0]
        && wb_dat_i[`RMS_F_STOP];
      seq_launch <= wr_take && (wb_adr_i[3:2] == `RMS_OFS_CONTROL) && wb_sel_i[0]
        && wb_dat_i[`RMS_F_LAUNCH] && !wb_dat_i[`RMS_F_STOP];
    end
  end

  // Timer chain: timer one restarts on launch or second event, timer two on first event
  assign tick_start[0] = (seq_launch && state_reg == st_halted) || tick[1];
  assign tick_start[1] = tick[0];
  assign first_timer_event = tick[0];
  assign second_timer_event = tick[1];

  // Both timers share one structure; the chain runs whatever the state is
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_timer
      rms_tick_timer #(
        .RES1_CYC(RES1_CYC),
        .RES2_CYC(RES2_CYC),
        .RES3_CYC(RES3_CYC)
      ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(tick_start[gi]),
        .abort_i(seq_stop),
        .scale_i(gi == 0 ? timer_reg[`RMS_F_T1_SCALE_HI:`RMS_F_T1_SCALE_LO]
                         : timer_reg[`RMS_F_T2_SCALE_HI:`RMS_F_T2_SCALE_LO]),
        .count_i(gi == 0 ? timer_reg[`RMS_F_T1_CNT_HI:`RMS_F_T1_CNT_LO]
                         : timer_reg[`RMS_F_T2_CNT_HI:`RMS_F_T2_CNT_LO]),
        .tick_o(tick[gi])
      );
    end
  endgenerate

  // Transitory states resolved in the same cycle
  assign lowpower_target = lowpower_choice ? st_idle : st_halted;
  assign receive_timeout = strength_timeout_i || lead_in_timeout_i || match_timeout_i;

  // Timeout exit choice
  always_comb begin
    case (timeout_exit_select)
      2'h0: timeout_target = st_rx;
      2'h1: timeout_target = st_tx;
      2'h2: timeout_target = lowpower_target;
      default: timeout_target = st_halted;
    endcase
  end

  // Next sequencer state; stop beats everything, second timer beats receive events
  always_comb begin
    state_next = state_reg;
    relaunch_next = 1'b0;
    if (seq_stop) begin
      state_next = st_halted;
    end else begin
      case (state_reg)
        st_halted: begin
          if (seq_launch) begin
            case (start_exit_select)
              2'h0: state_next = lowpower_target;
              2'h1: state_next = st_rx;
              2'h2: state_next = st_tx;
              default: state_next = st_tx_wait_level;
            endcase
          end
        end
        st_idle: begin
          // Only the first timer is heard here
          if (first_timer_event) begin
            state_next = idle_exit_select ? st_rx : st_tx;
          end
        end
        st_tx_wait_level: begin
          if (queue_level_event_i) begin
            state_next = st_tx;
          end
        end
        st_tx: begin
          if (tx_done_event_i) begin
            state_next = tx_exit_select ? st_rx : lowpower_target;
          end
        end
        st_rx: begin
          if (second_timer_event) begin
            state_next = lowpower_target;
          end else if (receive_timeout || (rx_exit_select == 3'h3 && rx_payload_event_i
                       && crc_on && !check_pass_event_i)) begin
            state_next = timeout_target;
            relaunch_next = (timeout_exit_select == 2'h0);
          end else begin
            case (rx_exit_select)
              3'h1: if (rx_payload_event_i) state_next = st_pkt_done;
              3'h2: if (rx_payload_event_i) state_next = lowpower_target;
              3'h3: if (check_pass_event_i) state_next = st_pkt_done;
              3'h4: if (strength_event_i) state_next = st_halted;
              3'h5: if (match_event_i) state_next = st_halted;
              3'h6: if (lead_in_event_i) state_next = st_halted;
              default: state_next = st_rx; // Codes 0 and 7 have no exit
            endcase
          end
        end
        st_pkt_done: begin
          case (pkt_done_exit_select)
            3'h0: state_next = st_halted;
            3'h1: state_next = st_pkt_wait_drain;
            3'h2: state_next = lowpower_target;
            3'h3: state_next = st_synth;
            3'h4: state_next = st_rx;
            default: state_next = st_pkt_done; // Unused codes hold
          endcase
        end
        st_pkt_wait_drain: begin
          if (queue_drained_event_i) begin
            state_next = st_tx;
          end
        end
        st_synth: state_next = st_rx; // One cycle of synthesiser settling
        default: state_next = st_halted;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= st_halted;
    end else begin
      state_reg <= state_next;
    end
  end

  // Initial low-power mode caught on a taken launch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_sleep_reg <= 1'b0;
    end else if (seq_launch && !seq_stop && state_reg == st_halted) begin
      init_sleep_reg <= chip_sleep_i;
    end
  end

  // Remember that a run happened, so the halted mode keeps the launch mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ran_reg <= 1'b0;
    end else if (seq_active_o) begin
      ran_reg <= 1'b1;
    end
  end

  // Before any run the halted mode follows the chip; after one it holds the launch mode.
  // A launch that halts at once shows the mode being caught in that same cycle.
  assign halt_sleep = ((ran_reg || seq_active_o) && !(seq_launch && state_reg == st_halted))
    ? init_sleep_reg : chip_sleep_i;

  // Mode outputs registered from the next state so they change with the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chip_mode_o <= mode_standby;
      seq_active_o <= 1'b0;
      reception_relaunch_o <= 1'b0;
    end else begin
      seq_active_o <= (state_next != st_halted);
      reception_relaunch_o <= relaunch_next && !seq_stop;
      case (state_next)
        st_halted: begin
          // Off: hand the chip back its launch mode
          chip_mode_o <= halt_sleep ? mode_sleep : mode_standby;
        end
        st_idle: chip_mode_o <= idle_lowpower_select ? mode_sleep : mode_standby;
        st_tx: chip_mode_o <= mode_tx;
        st_rx, st_pkt_done, st_pkt_wait_drain: chip_mode_o <= mode_rx;
        st_synth: chip_mode_o <= mode_synth;
        default: chip_mode_o <= init_sleep_reg ? mode_sleep : mode_standby;
      endcase
    end
  end

  // Checks
  a_stop_halts: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_stop |=> state_reg == st_halted && !seq_active_o)
    else $error("stop did not halt the sequencer");
  a_idle_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == st_idle |-> chip_mode_o == (idle_lowpower_select ? mode_sleep : mode_standby))
    else $error("idle chip mode wrong");
  a_idle_deaf: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == st_idle && !first_timer_event && !seq_stop |=> state_reg == st_idle)
    else $error("idle left without first timer");
  a_idle_exit: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == st_idle && first_timer_event && !seq_stop
    |=> state_reg == (idle_exit_select ? st_rx : st_tx))
    else $error("idle exit wrong");
  a_rx_second_timer: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == st_rx && second_timer_event && !seq_stop
    |=> state_reg == $past(lowpower_target))
    else $error("second timer did not leave receive");
  a_tx_exit: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == st_tx && tx_done_event_i && !seq_stop && tx_exit_select |=> state_reg == st_rx)
    else $error("transmit exit to receive wrong");
  a_timeout_relaunch: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == st_rx && !second_timer_event && !seq_stop && strength_timeout_i
    && timeout_exit_select == 2'h0 |=> reception_relaunch_o && state_reg == st_rx)
    else $error("timeout relaunch missing");
  a_timer_chain: assert property (@(posedge clk_i) disable iff (rst_i)
    first_timer_event |-> !second_timer_event)
    else $error("timers fired together");
  a_halt_restores: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(seq_active_o) |-> chip_mode_o == (init_sleep_reg ? mode_sleep : mode_standby))
    else $error("initial mode not restored");
  a_launch_branch: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == st_halted && seq_launch && !seq_stop && start_exit_select == 2'h2
    |=> state_reg == st_tx ##1 chip_mode_o == mode_tx)
    else $error("launch to transmit wrong");
  c_rx_to_pkt: cover property (@(posedge clk_i) state_reg == st_rx ##1 state_reg == st_pkt_done);
  c_periodic: cover property (@(posedge clk_i) first_timer_event ##[1:1000] second_timer_event);
  c_idle_cycle: cover property (@(posedge clk_i) state_reg == st_idle ##1 state_reg == st_tx);
endmodule : rms_sequencer

// ===== logic/rms_tick_timer.sv
// One sequencer timer: resolution prescaler times a coefficient count
`timescale 1ns/1ps
module rms_tick_timer #(
  parameter int unsigned RES1_CYC = 3200,
  parameter int unsigned RES2_CYC = 205000,
  parameter int unsigned RES3_CYC = 13100000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [1:0] scale_i,
  input wire logic [7:0] count_i,
  // Event out
  output logic tick_o
);
  logic running_reg; // Timer counting
  logic [23:0] pre_reg; // Cycles inside one resolution step
  logic [7:0] coef_reg; // Steps elapsed
  logic [23:0] res_last; // Last prescaler value for the scale
  logic step_end;

  // Pick the step length; scale 0 never runs so its value is unused
  always_comb begin
    case (scale_i)
      2'h1: res_last = 24'(RES1_CYC - 1);
      2'h2: res_last = 24'(RES2_CYC - 1);
      default: res_last = 24'(RES3_CYC - 1);
    endcase
  end

  assign step_end = running_reg && (pre_reg == res_last);

  // Run flag: a zero scale or zero coefficient never arms
  always_ff @(posedge clk_i) begin
    if (rst_i || abort_i) begin
      running_reg <= 1'b0;
    end else if (start_i) begin
      running_reg <= (scale_i != 2'h0) && (count_i != 8'h00);
    end else if (step_end && (coef_reg + 8'h01 == count_i)) begin
      running_reg <= 1'b0;
    end
  end

  // Prescaler and coefficient counters
  always_ff @(posedge clk_i) begin
    if (rst_i || start_i) begin
      pre_reg <= 24'h000000;
      coef_reg <= 8'h00;
    end else if (step_end) begin
      pre_reg <= 24'h000000;
      coef_reg <= coef_reg + 8'h01;
    end else if (running_reg) begin
      pre_reg <= pre_reg + 24'h000001;
    end
  end

  // Pulse once when the last step closes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= step_end && !start_i && !abort_i && (coef_reg + 8'h01 == count_i);
    end
  end
endmodule : rms_tick_timer
